// ===== rla_line_adapter.sv
`timescale 1ns/1ns
// Function
// RL1: Half-duplex mode raises driver enable one bit time before first stop bit.
// RL2: Driver enable stays high while shift register or holding FIFO hold data.
// RL3: After both empty, hold driver enable for 0 to 15 extra bit times.
// RL4: Delay count starts only when both empty; a new write cancels it.
// RL5: Delay counter sized for fifteen, loaded from the configured field.
// RL6: The transmit FIFO feeding the transmitter holds 128 bytes.
// RL7: Large-block mode: interrupt on FIFO empty below threshold or threshold crossed.
// RL8: Large-block cleared in half duplex: interrupt only on shift register empty.
// RL9: Half duplex without receive-while-sending disables the receiver while sending.
// RL10: Infrared coder runs from a sixteen-times-baud oversample tick.
// RL11: A one is no pulse in its bit; a zero is exactly one pulse.
// RL12: Each infrared pulse lasts at least 1.6 us and three oversample clocks.
// RL13: While encoder input is high, output stays low and counter is cleared.
// RL14: Low input pulses the output from oversample clock 7 to 10, every bit.
// RL15: Encoded transmit pulses are positive-going.
// RL16: After reset decoder output is high and its 4-bit counter cleared.
// RL17: Receive falling edge drives decoder output low for 16 oversample clocks.
// RL18: Without falling edges the decoder output stays high.
// RL19: Sample decoded data at clock 8 after start edge, then every 16.
// RL20: Decoder accepts negative or positive pulses, acting on falling edges.
// RL21: Each infrared word is framed by start bit 0 and stop bit 1.
// RL22: Infrared engine evaluates single bits, up to 115.2 kbps, rates matching.
module rla_line_adapter
  import rla_pkg::*;
#(
  parameter int FIFO_DEPTH = 128,
  parameter int TX_THRESH  = 16
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // UART core side
  input  wire logic        os_tick,
  input  wire logic        tx_serial,
  input  wire logic        tx_shift_busy,
  input  wire logic        tx_stop_next,
  input  wire logic        fifo_wr,
  input  wire logic [7:0]  fifo_level,
  output logic             rx_serial,
  output logic             rx_enable,
  output logic             rx_strobe,
  output logic             tx_irq,
  // Line side
  input  wire logic        rx_pin,
  output logic             tx_pin,
  output logic             half_duplex_drive_enable
);
`include "rla_cfg.svh"

  localparam logic [7:0] THRESH = 8'(TX_THRESH);
  localparam int PULSE_CYC = `RLA_PULSE_MIN_CYC;

  initial begin
    if (FIFO_DEPTH != 128 || TX_THRESH < 1 || TX_THRESH >= FIFO_DEPTH)
      $error("rla_line_adapter: unsupported FIFO depth or threshold");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic rx_s1_q, rx_s2_q, rx_s3_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
    end
  end
  wire rx_fall = rx_s3_q & ~rx_s2_q; // RL20

  ////////////////////////////////////////////////////////////////////////////
  // Registers over APB
  logic [31:0] ctrl_q;
  wire sel_ctrl = (paddr == `RLA_CTRL_ADDR);
  wire sel_stat = (paddr == `RLA_STAT_ADDR);
  wire acc      = psel & penable;
  wire wr_ctrl  = acc & pwrite & sel_ctrl;
  wire hd_en    = ctrl_q[`RLA_HD_EN_BIT];
  wire lg_mode  = ctrl_q[`RLA_LG_BIT];
  wire rws      = ctrl_q[`RLA_RWS_BIT];
  wire sir_en   = ctrl_q[`RLA_SIR_EN_BIT];
  wire [3:0] dly_field = ctrl_q[`RLA_DLY_MSB:`RLA_DLY_LSB];
  logic [31:0] stat_word;
  logic [31:0] rd_word;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q  <= `RLA_CTRL_RST;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      if (wr_ctrl && pready)
        ctrl_q <= pwdata & 32'h0000_00FF;
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~(sel_ctrl | sel_stat);
      if (psel && !penable)
        prdata <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half-duplex driver enable and turnaround delay
  rla_de_state_t de_state_q;
  logic [3:0]    bit_left_q;
  logic [3:0]    os_cnt_q;
  wire  tx_pending = tx_shift_busy | (fifo_level != 8'h00);  // RL2
  wire  bit_end    = os_tick & (os_cnt_q == `RLA_OS_PER_BIT);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      de_state_q <= RLA_IDLE;
      bit_left_q <= 4'h0;
      os_cnt_q   <= 4'h0;
      half_duplex_drive_enable <= 1'b0;
    end else begin
      if (os_tick)
        os_cnt_q <= os_cnt_q + 4'h1;
      case (de_state_q)
        RLA_IDLE: begin
          if (hd_en && tx_stop_next)   // RL1
            de_state_q <= RLA_SEND;
        end
        RLA_SEND: begin
          if (!tx_pending) begin     // RL4
            de_state_q <= RLA_HOLD;
            bit_left_q <= dly_field; // RL5
            os_cnt_q   <= 4'h0;
          end
        end
        RLA_HOLD: begin
          if (fifo_wr || tx_pending)  // RL4
            de_state_q <= RLA_SEND;
          else if (bit_left_q == 4'h0) // RL3
            de_state_q <= RLA_IDLE;
          else if (bit_end)
            bit_left_q <= bit_left_q - 4'h1;
        end
        default: de_state_q <= RLA_IDLE;
      endcase
      half_duplex_drive_enable <= hd_en & (de_state_q != RLA_IDLE); // RL1
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit interrupt policy
  logic shift_busy_q, level_above_q, fifo_nz_q;
  wire lvl_above   = fifo_level > THRESH;  // RL7
  wire fifo_emptied = fifo_nz_q & (fifo_level == 8'h00) & ~fifo_wr;
  wire crossed     = level_above_q & ~lvl_above;
  wire tsr_emptied = shift_busy_q & ~tx_shift_busy;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shift_busy_q  <= 1'b0;
      level_above_q <= 1'b0;
      fifo_nz_q     <= 1'b0;
      tx_irq        <= 1'b0;
    end else begin
      shift_busy_q  <= tx_shift_busy;
      level_above_q <= lvl_above;
      fifo_nz_q     <= (fifo_level != 8'h00);
      if (hd_en && !lg_mode)
        tx_irq <= tsr_emptied;                        // RL8
      else
        tx_irq <= crossed | (fifo_emptied & ~level_above_q); // RL7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Infrared encoder
  logic [3:0] enc_cnt_q;
  logic [7:0] pulse_cnt_q;
  wire pulse_start = os_tick & (enc_cnt_q == `RLA_PULSE_ON);
  wire pulse_stop  = os_tick & (enc_cnt_q == `RLA_PULSE_OFF);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enc_cnt_q   <= 4'h0;
      pulse_cnt_q <= 8'h00;
      tx_pin      <= 1'b0;
    end else if (!sir_en) begin
      enc_cnt_q   <= 4'h0;
      pulse_cnt_q <= 8'h00;
      tx_pin      <= tx_serial;
    end else if (tx_serial) begin
      enc_cnt_q   <= 4'h0;   // RL13
      pulse_cnt_q <= 8'h00;
      tx_pin      <= 1'b0;   // RL11
    end else begin
      if (os_tick)
        enc_cnt_q <= enc_cnt_q + 4'h1;  // RL10
      if (pulse_start) begin
        tx_pin      <= 1'b1;            // RL14 RL15
        pulse_cnt_q <= 8'h01;
      end else if (tx_pin) begin
        if (pulse_cnt_q != 8'hFF)
          pulse_cnt_q <= pulse_cnt_q + 8'h01;
        // End after clock 10 but never below the least width
        if ((pulse_stop || enc_cnt_q > `RLA_PULSE_OFF)
            && pulse_cnt_q >= 8'(PULSE_CYC))  // RL12
          tx_pin <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Infrared decoder and strobe
  logic [3:0] dec_cnt_q;
  logic       dec_low_q, edge_seen_q;
  logic [3:0] stb_cnt_q;
  logic [3:0] stb_idx_q;
  logic       stb_run_q;
  logic       rx_dec_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dec_cnt_q   <= 4'h0;  // RL16
      dec_low_q   <= 1'b0;
      edge_seen_q <= 1'b0;
    end else begin
      if (rx_fall)
        edge_seen_q <= 1'b1;
      if (os_tick && (edge_seen_q || rx_fall)) begin
        edge_seen_q <= 1'b0;
        dec_low_q   <= 1'b1;  // RL17
        dec_cnt_q   <= 4'h0;
      end else if (os_tick && dec_low_q) begin
        dec_cnt_q <= dec_cnt_q + 4'h1;
        if (dec_cnt_q == `RLA_OS_PER_BIT)
          dec_low_q <= 1'b0;   // RL17 RL18
      end
    end
  end

  wire rx_line = sir_en ? ~dec_low_q : rx_s3_q;       // RL11
  wire rx_gate = ~hd_en | rws | ~half_duplex_drive_enable; // RL9

  // Mid-bit strobe synchronised by the start-bit falling edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stb_cnt_q <= 4'h0;
      stb_idx_q <= 4'h0;
      stb_run_q <= 1'b0;
      rx_strobe <= 1'b0;
      rx_dec_q  <= 1'b1;
      rx_serial <= 1'b1;     // RL16
      rx_enable <= 1'b1;
    end else begin
      rx_dec_q  <= rx_line;
      rx_serial <= rx_line | ~rx_gate;
      rx_enable <= rx_gate;  // RL9
      rx_strobe <= 1'b0;
      if (!stb_run_q && rx_dec_q && !rx_line) begin
        stb_run_q <= 1'b1;   // RL21
        stb_cnt_q <= 4'h0;
        stb_idx_q <= 4'h0;
      end else if (stb_run_q && os_tick) begin
        stb_cnt_q <= stb_cnt_q + 4'h1;
        if (stb_cnt_q == `RLA_STROBE_AT) begin
          rx_strobe <= rx_gate;  // RL19 RL22
          stb_idx_q <= stb_idx_q + 4'h1;
          // Ones inside the word must not end the frame early
          if (stb_idx_q == `RLA_FRAME_LAST)
            stb_run_q <= 1'b0;   // stop bit seen
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status read word
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[0] = half_duplex_drive_enable;
    stat_word[1] = tx_irq;
    stat_word[2] = rx_enable;
    stat_word[3] = ~dec_low_q;
    stat_word[5:4] = de_state_q;
  end
  assign rd_word = sel_ctrl ? ctrl_q : (sel_stat ? stat_word : 32'h0000_0000);

endmodule : rla_line_adapter

// ===== rla_cfg.svh
`ifndef RLA_CFG_SVH
`define RLA_CFG_SVH
// Register byte addresses
`define RLA_CTRL_ADDR      12'h000
`define RLA_STAT_ADDR      12'h004
// Control field positions
`define RLA_HD_EN_BIT      0
`define RLA_LG_BIT         1
`define RLA_RWS_BIT        2
`define RLA_SIR_EN_BIT     3
`define RLA_DLY_LSB        4
`define RLA_DLY_MSB        7
`define RLA_CTRL_RST       32'h0000_0000
// Oversample timing, in oversample ticks
`define RLA_OS_PER_BIT     4'hF
`define RLA_PULSE_ON       4'h6
`define RLA_PULSE_OFF      4'h9
`define RLA_STROBE_AT      4'h7
// Strobe index of the stop bit: start, eight data bits, stop
`define RLA_FRAME_LAST     4'h9
// Least infrared pulse width in ns, and its cycle count at 100 MHz
`define RLA_PULSE_MIN_NS   1600
`define RLA_CLK_NS         10
`define RLA_PULSE_MIN_CYC  ((`RLA_PULSE_MIN_NS + `RLA_CLK_NS - 1) / `RLA_CLK_NS)
`endif

// ===== rla_pkg.sv
package rla_pkg;
  typedef enum logic [1:0] {RLA_IDLE, RLA_SEND, RLA_HOLD} rla_de_state_t;
endpackage : rla_pkg

// ===== rla_line_adapter_monitor.sv
`timescale 1ns/1ns
module rla_line_adapter_monitor (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       os_tick,
  input wire logic       tx_stop_next,
  input wire logic       tx_shift_busy,
  input wire logic [7:0] fifo_level,
  input wire logic       rx_serial,
  input wire logic       rx_enable,
  input wire logic       rx_strobe,
  input wire logic       tx_irq,
  input wire logic       tx_pin,
  input wire logic       half_duplex_drive_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [8:0] hi_q;
  logic [4:0] lo_q;
  logic [3:0] ph_q;
  // Line pulse width, decoded low ticks, ticks since decoded fall
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hi_q <= 9'h000;
      lo_q <= 5'h00;
      ph_q <= 4'h0;
    end else begin
      hi_q <= tx_pin ? ((hi_q == 9'h1FF) ? hi_q : hi_q + 9'h001) : 9'h000;
      lo_q <= rx_serial ? 5'h00 : lo_q + {4'h0, os_tick};
      ph_q <= $fell(rx_serial) ? 4'h0 : ph_q + {3'h0, os_tick};
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  chk_apb_answer: assert property (s_setup |=> s_access)
    else $error("no ready in first access cycle");
  chk_pulse_width: assert property ($fell(tx_pin) |-> hi_q >= 9'h09F)
    else $error("line pulse too short");
  chk_dec_width: assert property ($rose(rx_serial) && rx_enable |-> lo_q == 5'h10)
    else $error("decoded low not sixteen ticks");
  chk_strobe_mid: assert property (rx_strobe |-> (ph_q == 4'h7 && os_tick) ||
    (ph_q == 4'h8 && $past(os_tick))) else $error("strobe off mid bit");
  chk_de_rise: assert property ($rose(half_duplex_drive_enable) |-> $past(tx_stop_next, 2))
    else $error("driver enable rose without cause");
  chk_de_hold: assert property (half_duplex_drive_enable && (tx_shift_busy ||
    fifo_level != 8'h00) |=> half_duplex_drive_enable) else $error("driver enable dropped");
  chk_rx_gate: assert property (!rx_enable |-> rx_serial)
    else $error("gated receiver passes data");
  chk_irq_pulse: assert property (tx_irq |=> !tx_irq)
    else $error("interrupt event longer than one cycle");
endmodule : rla_line_adapter_monitor
bind rla_line_adapter rla_line_adapter_monitor u_mon (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pready(pready), .os_tick(os_tick), .tx_stop_next(tx_stop_next),
  .tx_shift_busy(tx_shift_busy), .fifo_level(fifo_level), .rx_serial(rx_serial),
  .rx_enable(rx_enable), .rx_strobe(rx_strobe), .tx_irq(tx_irq), .tx_pin(tx_pin),
  .half_duplex_drive_enable(half_duplex_drive_enable));

// ===== rla_ir_optics.sv
`timescale 1ns/1ns
module rla_ir_optics (
  input wire logic clk,
  input wire logic os_tick,
  output logic     rx_pin
);
  initial rx_pin = 1'b1;
  // Waits for n oversample ticks
  task automatic ticks(input int n);
    repeat (n) do @(posedge clk); while (os_tick !== 1'b1);
  endtask : ticks
  // Sets the idle level of the detector and lets it settle
  task automatic set_idle(input logic pos);
    rx_pin <= !pos;
    ticks(200);
  endtask : set_idle
  // One pulse in ticks 7..9 of each zero bit, none for a one
  task automatic send_word(input logic [7:0] b, input logic pos);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int t = 1; t <= 16; t++) begin
        ticks(1);
        rx_pin <= (!f[i] && t >= 7 && t < 10) ? pos : !pos;
      end
    end
  endtask : send_word
endmodule : rla_ir_optics

// ===== rla_line_adapter_tb.sv
`timescale 1ns/1ns
module rla_line_adapter_tb;
  `include "rla_cfg.svh"
  logic        clk, rstn, psel, penable, pwrite, os_tick, tx_serial, tx_shift_busy;
  logic        tx_stop_next, fifo_wr, pready, pslverr, rx_serial, rx_enable, rx_strobe;
  logic        tx_irq, rx_pin, tx_pin, de, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  fifo_level;
  int          n_fail, samples_checked, tick_n, irq_n, d, n, np, nh;
  logic        cap[$];
  rla_line_adapter DUT (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .os_tick(os_tick), .tx_serial(tx_serial),
    .tx_shift_busy(tx_shift_busy), .tx_stop_next(tx_stop_next), .fifo_wr(fifo_wr),
    .fifo_level(fifo_level), .rx_serial(rx_serial), .rx_enable(rx_enable),
    .rx_strobe(rx_strobe), .tx_irq(tx_irq), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .half_duplex_drive_enable(de));
  rla_ir_optics u_opt (.clk(clk), .os_tick(os_tick), .rx_pin(rx_pin));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Oversample tick every 54 clocks, strobe capture, interrupt count
  always @(posedge clk) begin
    tick_n <= (tick_n == 53) ? 0 : tick_n + 1;
    os_tick <= (tick_n == 53);
    if (rx_strobe === 1'b1) cap.push_back(rx_serial);
    if (tx_irq === 1'b1) irq_n++;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks=%0d fails=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin n_fail++; test_done(); end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // Decodes the captured strobes after the first zero
  task automatic chk_word(input logic [7:0] exp);
    int i;
    logic [7:0] got;
    i = 0;
    got = 8'h00;
    while (i < cap.size() && cap[i] !== 1'b0) i++;
    for (int j = 0; j < 8; j++) if (i + 1 + j < cap.size()) got[j] = cap[i + 1 + j];
    check(got, exp);
  endtask : chk_word
  initial begin
    #900000 n_fail++;
    test_done();
  end
  initial begin
    {rstn, psel, penable, pwrite, os_tick, tx_shift_busy, tx_stop_next, fifo_wr} = 8'h00;
    {paddr, pwdata, fifo_level, tick_n, irq_n} = '0;
    tx_serial = 1'b1;
    void'($urandom(32'hc090));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check({tx_pin, de, rx_serial, rx_enable, tx_irq}, 5'h06);
    d = $urandom_range(1, 3);
    apb(1'b1, `RLA_CTRL_ADDR, d * 16 + 1);
    apb(1'b0, `RLA_CTRL_ADDR, 0);
    check(r, d * 16 + 1);
    apb(1'b0, 12'h008, 0);
    check(e, 1);
    check(r, 0);
    tx_shift_busy <= 1'b1;
    fifo_level <= 8'($urandom_range(1, 128));
    tx_stop_next <= 1'b1;
    @(posedge clk) tx_stop_next <= 1'b0;
    @(posedge clk);
    @(posedge clk) check(de, 1);
    u_opt.ticks(40);
    check({de, rx_enable}, 2'h2);
    n = irq_n;
    fifo_level <= 8'h00;
    u_opt.ticks(5);
    check(de, 1);
    check(irq_n, n);
    tx_shift_busy <= 1'b0;
    u_opt.ticks(8);
    fifo_wr <= 1'b1;
    @(posedge clk) fifo_wr <= 1'b0;
    np = 0;
    while (de === 1'b1 && np < 300) begin u_opt.ticks(1); np++; end
    check(np >= d * 16 && np <= d * 16 + 1, 1);
    check(irq_n, n + 1);
    check(rx_enable, 1);
    apb(1'b1, `RLA_CTRL_ADDR, 32'h08);
    foreach (r[i]) if (i < 4) begin
      tx_serial <= 1'b1;
      u_opt.ticks(1);
      tx_serial <= r[i + 4] ^ (i == 2);
      {np, nh} = '0;
      repeat (16 * 54) @(posedge clk) begin
        if (tx_pin === 1'b1) nh++;
        if (tx_pin === 1'b1 && nh == 1) np++;
      end
      check({np[0], nh >= 160 && nh <= 170}, (r[i + 4] ^ (i == 2)) ? 0 : 3);
    end
    tx_serial <= 1'b1;
    n = irq_n;
    fifo_level <= 8'($urandom_range(17, 128));
    u_opt.ticks(2);
    fifo_level <= 8'h05;
    u_opt.ticks(2);
    check(irq_n, n + 1);
    fifo_level <= 8'h00;
    u_opt.ticks(2);
    check(irq_n, n + 2);
    u_opt.set_idle(1'b0);
    cap.delete();
    u_opt.send_word(8'h55, 1'b0);
    u_opt.ticks(20);
    chk_word(8'h55);
    u_opt.set_idle(1'b1);
    cap.delete();
    u_opt.send_word(8'hD5, 1'b1);
    u_opt.ticks(20);
    chk_word(8'hD5);
    test_done();
  end
endmodule : rla_line_adapter_tb
